// >>> src/blsr_regs.sv
// Purpose: current limit configuration and operating status registers of a boost converter
// Assumes: converter status inputs are synchronous to clk; host reaches registers over the serial port
// Notes:   limit controls are registered, so they follow a register or mode change by one clock
// Functional notes
// - the 9.4A bypass limit is applied in bypass mode while config bit 7 is 0.
// - the 6.5A bypass limit is applied in bypass mode while config bit 6 is 0.
// - the valley current limit is enforced in boost mode while config bit 5 is 0.
// - during boost soft-start the valley limit is 2000mA if config bit 4 is 1, else the code value.
// - the valley code gives 4000mA plus 500mA per step, 9000mA for codes 10 to 15, default 0110.
// - a register reset loads 0x16 into the limit register and 0x10 into the status register.
// - status bit 7 is set when thermal shutdown trips and reads 0 otherwise.
// - status bit 5 shows pulse-frequency mode (1) or pulse-width mode (0).
// - status bit 4 shows boost operation (1) or bypass (0).
// - status bit 3 is set when the bypass current limit triggers in bypass mode.
// - status bit 2 is set when the valley limit triggers in boost mode.
// - status bit 1 is set whenever a fault occurs.
// - the four flags clear when the host reads the status register.
// - status bit 0 is 1 while the output is in regulation and 0 otherwise.
// - status bit 0 is held at 1 while the converter is forced into bypass.
// - a register-reset request restores defaults and then the reset bit is cleared by the device.
`timescale 1ns/100ps
`default_nettype none
module blsr_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary bus address
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // serial management pins
  input  wire logic         scl_i,
  input  wire logic         sda_i,
  output logic              sda_o,
  output logic              sda_oe_n,
  // register reset handshake with the configuration register
  input  wire logic         reg_reset_req,
  output logic              reg_reset_clear,
  // converter state
  input  wire logic         boost_mode,
  input  wire logic         pfm_mode,
  input  wire logic         soft_start,
  input  wire logic         forced_bypass,
  input  wire logic         vout_in_range,
  // converter events
  input  wire logic         thermal_trip,
  input  wire logic         bypass_limit_hit,
  input  wire logic         boost_limit_hit,
  input  wire logic         fault_event,
  // limit controls to the power stage
  output logic              bypass_high_limit_en,
  output logic              bypass_low_limit_en,
  output logic              valley_limit_en,
  output logic [13:0]       valley_limit_ma
);
  import blsr_pkg::*;

  logic       wr_en, rd_en;
  logic [7:0] reg_addr, wr_data, rd_data;
  logic [7:0] current_limit_config;
  logic       thermal_trip_seen, bypass_limit_seen, boost_limit_seen, fault_seen;
  logic       pulse_freq_active, boost_active, output_in_regulation;

  blsr_serial #(.DEV_ADDR(DEV_ADDR)) u_serial (
    .clk      (clk),
    .rstn     (rstn),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .sda_o    (sda_o),
    .sda_oe_n (sda_oe_n),
    .wr_en    (wr_en),
    .rd_en    (rd_en),
    .reg_addr (reg_addr),
    .wr_data  (wr_data),
    .rd_data  (rd_data)
  );

  // decode
  wire        limit_sel  = (reg_addr == LIMIT_ADDR);
  wire        status_sel = (reg_addr == STATUS_ADDR);
  wire        limit_wr   = wr_en & limit_sel;
  wire        status_rd  = rd_en & status_sel;
  wire [7:0]  operating_status = {thermal_trip_seen, 1'b0, pulse_freq_active, boost_active,
                                  bypass_limit_seen, boost_limit_seen, fault_seen, output_in_regulation};
  assign rd_data = limit_sel ? current_limit_config : (status_sel ? operating_status : 8'h00);

  // flag set terms; bypass and boost limits only count in their own mode
  wire        set_thermal = thermal_trip;
  wire        set_bypass  = bypass_limit_hit & ~boost_mode;
  wire        set_boost   = boost_limit_hit & boost_mode;
  wire        set_fault   = fault_event;

  // a set in the read cycle wins, so an event coincident with the read is kept for the next read
  wire        next_thermal = set_thermal | (thermal_trip_seen & ~status_rd);
  wire        next_bypass  = set_bypass  | (bypass_limit_seen & ~status_rd);
  wire        next_boost   = set_boost   | (boost_limit_seen  & ~status_rd);
  wire        next_fault   = set_fault   | (fault_seen        & ~status_rd);

  // limit selection
  wire [3:0]  valley_limit_code = current_limit_config[3:0];
  wire [13:0] code_ma = (valley_limit_code >= VALLEY_SAT_CODE) ? VALLEY_MAX_MA :
                        VALLEY_BASE_MA + 14'(VALLEY_STEP_MA * {10'h000, valley_limit_code});
  wire        ss_fixed = soft_start & current_limit_config[SOFTSTART_BIT];
  wire [13:0] next_valley_ma = ss_fixed ? SOFTSTART_MA : code_ma;
  wire        next_hi_en = ~current_limit_config[HI_DIS_BIT] & ~boost_mode;
  wire        next_lo_en = ~current_limit_config[LO_DIS_BIT] & ~boost_mode;
  wire        next_valley_en = ~current_limit_config[VALLEY_DIS_BIT] & boost_mode;
  wire        next_pgood = vout_in_range | forced_bypass;

  // configuration register; register reset overrides a coincident host write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      current_limit_config <= LIMIT_RESET;
      reg_reset_clear      <= 1'b0;
    end else begin
      reg_reset_clear <= reg_reset_req;
      if (reg_reset_req) current_limit_config <= LIMIT_RESET;
      else if (limit_wr) current_limit_config <= wr_data;
    end
  end

  // status register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {thermal_trip_seen, pulse_freq_active, boost_active, bypass_limit_seen} <= 4'h0;
      {boost_limit_seen, fault_seen, output_in_regulation} <= 3'h0;
      boost_active <= STATUS_RESET[BOOST_BIT];
    end else if (reg_reset_req) begin
      // defaults for one cycle, live bits resume on the next
      thermal_trip_seen    <= STATUS_RESET[THERMAL_BIT];
      pulse_freq_active    <= STATUS_RESET[PFM_BIT];
      boost_active         <= STATUS_RESET[BOOST_BIT];
      bypass_limit_seen    <= STATUS_RESET[BYP_LIM_BIT];
      boost_limit_seen     <= STATUS_RESET[BST_LIM_BIT];
      fault_seen           <= STATUS_RESET[FAULT_BIT];
      output_in_regulation <= STATUS_RESET[PGOOD_BIT];
    end else begin
      thermal_trip_seen    <= next_thermal;
      bypass_limit_seen    <= next_bypass;
      boost_limit_seen     <= next_boost;
      fault_seen           <= next_fault;
      pulse_freq_active    <= pfm_mode;
      boost_active         <= boost_mode;
      output_in_regulation <= next_pgood;
    end
  end

  // limit controls
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bypass_high_limit_en <= 1'b0;
      bypass_low_limit_en  <= 1'b0;
      valley_limit_en      <= 1'b0;
      // matches the default code, so the limit does not jump on the first edge after reset while soft_start is low
      valley_limit_ma      <= VALLEY_BASE_MA + 14'(VALLEY_STEP_MA * {10'h000, LIMIT_RESET[3:0]});
    end else begin
      bypass_high_limit_en <= next_hi_en;
      bypass_low_limit_en  <= next_lo_en;
      valley_limit_en      <= next_valley_en;
      valley_limit_ma      <= next_valley_ma;
    end
  end

  // checks
  chk_high_limit_apply: assert property (@(posedge clk) disable iff (!rstn)
    (!boost_mode && !current_limit_config[HI_DIS_BIT]) |=> bypass_high_limit_en)
    else $error("high bypass limit not applied");
  chk_low_limit_off: assert property (@(posedge clk) disable iff (!rstn)
    (current_limit_config[LO_DIS_BIT] || boost_mode) |=> !bypass_low_limit_en)
    else $error("low bypass limit applied when off");
  chk_valley_enforce: assert property (@(posedge clk) disable iff (!rstn)
    valley_limit_en |-> $past(boost_mode) && !$past(current_limit_config[VALLEY_DIS_BIT]))
    else $error("valley limit enable without cause");
  chk_softstart_fixed: assert property (@(posedge clk) disable iff (!rstn)
    (soft_start && current_limit_config[SOFTSTART_BIT]) |=> valley_limit_ma == 14'h07d0)
    else $error("soft-start valley limit not 2000mA");
  chk_code_saturate: assert property (@(posedge clk) disable iff (!rstn)
    (!ss_fixed && valley_limit_code >= 4'ha) |=> valley_limit_ma == 14'h2328)
    else $error("valley code above 9 not 9000mA");
  chk_code_default: assert property (@(posedge clk) disable iff (!rstn)
    (!ss_fixed && valley_limit_code == 4'h6) |=> valley_limit_ma == 14'h1b58)
    else $error("default code not 7000mA");
  chk_reset_defaults: assert property (@(posedge clk) disable iff (!rstn)
    reg_reset_req |=> current_limit_config == 8'h16 && operating_status == 8'h10 && reg_reset_clear)
    else $error("register reset did not restore defaults");
  chk_thermal_set: assert property (@(posedge clk) disable iff (!rstn)
    (thermal_trip && !reg_reset_req) |=> thermal_trip_seen)
    else $error("thermal flag missed");
  chk_mode_bits: assert property (@(posedge clk) disable iff (!rstn)
    !reg_reset_req |=> boost_active == $past(boost_mode) && pulse_freq_active == $past(pfm_mode))
    else $error("mode status bits wrong");
  chk_bypass_flag: assert property (@(posedge clk) disable iff (!rstn)
    (bypass_limit_hit && !boost_mode && !reg_reset_req) |=> bypass_limit_seen)
    else $error("bypass limit flag missed");
  chk_boost_flag: assert property (@(posedge clk) disable iff (!rstn)
    (boost_limit_hit && boost_mode && !reg_reset_req) |=> boost_limit_seen)
    else $error("boost limit flag missed");
  chk_read_clear: assert property (@(posedge clk) disable iff (!rstn)
    (status_rd && !fault_event) |=> !fault_seen)
    else $error("fault flag not cleared by read");
  chk_pgood_bypass: assert property (@(posedge clk) disable iff (!rstn)
    (forced_bypass && !reg_reset_req) |=> output_in_regulation)
    else $error("power good low in forced bypass");
  chk_flag_sticky: assert property (@(posedge clk) disable iff (!rstn)
    (fault_seen && !status_rd && !reg_reset_req) |=> fault_seen)
    else $error("fault flag lost before read");
endmodule : blsr_regs
`default_nettype wire

// >>> src/blsr_pkg.sv
// Purpose: shared constants for the boost limit/status register slice
// Assumes: 8-bit registers behind a two-wire serial management port
// Notes:   currents are in mA
package blsr_pkg;
  // register addresses
  localparam logic [7:0] LIMIT_ADDR     = 8'h03;
  localparam logic [7:0] STATUS_ADDR    = 8'h04;
  // reset values
  localparam logic [7:0] LIMIT_RESET    = 8'h16;
  localparam logic [7:0] STATUS_RESET   = 8'h10;
  // current_limit_config fields
  localparam int         HI_DIS_BIT     = 7;
  localparam int         LO_DIS_BIT     = 6;
  localparam int         VALLEY_DIS_BIT = 5;
  localparam int         SOFTSTART_BIT  = 4;
  // operating_status fields
  localparam int         THERMAL_BIT    = 7;
  localparam int         PFM_BIT        = 5;
  localparam int         BOOST_BIT      = 4;
  localparam int         BYP_LIM_BIT    = 3;
  localparam int         BST_LIM_BIT    = 2;
  localparam int         FAULT_BIT      = 1;
  localparam int         PGOOD_BIT      = 0;
  // valley limit table: 4000 mA + 500 mA per code, 9000 mA from code 10
  localparam logic [13:0] VALLEY_BASE_MA = 14'h0fa0;
  localparam logic [13:0] VALLEY_STEP_MA = 14'h01f4;
  localparam logic [13:0] VALLEY_MAX_MA  = 14'h2328;
  localparam logic [3:0]  VALLEY_SAT_CODE = 4'ha;
  localparam logic [13:0] SOFTSTART_MA   = 14'h07d0;
  // serial port states
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TXACK} blsr_ser_state_t;
endpackage : blsr_pkg

// >>> src/blsr_serial.sv
// Purpose: two-wire serial management slave giving byte register access
// Assumes: scl_i/sda_i synchronous to clk and much slower than clk
// Notes:   first byte after a write address is the register pointer; pointer auto-increments
`timescale 1ns/100ps
`default_nettype none
module blsr_serial #(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary bus address
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // serial pins (sda is open drain)
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  // register access
  output logic            wr_en,
  output logic            rd_en,
  output logic [7:0]      reg_addr,
  output logic [7:0]      wr_data,
  input  wire logic [7:0] rd_data
);
  import blsr_pkg::*;

  blsr_ser_state_t state;
  logic       scl_q, sda_q, rw, first;
  logic [7:0] sh;
  logic [3:0] cnt;

  wire scl_rise = scl_i & ~scl_q;
  wire scl_fall = ~scl_i & scl_q;
  wire start    = scl_i & scl_q & sda_q & ~sda_i;
  wire stop     = scl_i & scl_q & ~sda_q & sda_i;
  wire addr_hit = (sh[7:1] == DEV_ADDR);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE; scl_q <= 1'b1; sda_q <= 1'b1; rw <= 1'b0; first <= 1'b0;
      sh <= 8'h00; cnt <= 4'h0; sda_o <= 1'b0; sda_oe_n <= 1'b1;
      wr_en <= 1'b0; rd_en <= 1'b0; reg_addr <= 8'h00; wr_data <= 8'h00;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      if (wr_en || rd_en) reg_addr <= reg_addr + 8'h01;
      // the byte fetched on rd_en is loaded one cycle after the scl fall
      if (rd_en) begin
        sh       <= rd_data;
        sda_oe_n <= rd_data[7];
      end
      if (start) begin
        state <= ST_ADDR; cnt <= 4'h0; first <= 1'b1; sda_oe_n <= 1'b1;
      end else if (stop) begin
        state <= ST_IDLE; sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        case (state)
          ST_ADDR, ST_RX: begin
            sh  <= {sh[6:0], sda_i};
            cnt <= cnt + 4'h1;
          end
          ST_TX:    cnt <= cnt + 4'h1;
          ST_TXACK: state <= sda_i ? ST_IDLE : ST_ACK;
          default:  ;
        endcase
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: if (cnt == 4'h8) begin
            if (addr_hit) begin
              rw <= sh[0]; sda_oe_n <= 1'b0; state <= ST_ACK;
            end else begin
              state <= ST_IDLE;
            end
          end
          ST_ACK: begin
            cnt <= 4'h0;
            if (rw) begin
              rd_en <= 1'b1; state <= ST_TX;
            end else begin
              sda_oe_n <= 1'b1; state <= ST_RX;
            end
          end
          ST_RX: if (cnt == 4'h8) begin
            if (first) reg_addr <= sh;
            else begin
              wr_en <= 1'b1; wr_data <= sh;
            end
            first <= 1'b0; sda_oe_n <= 1'b0; state <= ST_ACK;
          end
          ST_TX: if (cnt == 4'h8) begin
            sda_oe_n <= 1'b1; state <= ST_TXACK;
          end else begin
            sh <= {sh[6:0], 1'b0}; sda_oe_n <= sh[6];
          end
          default: ;
        endcase
      end
    end
  end
endmodule : blsr_serial
`default_nettype wire

// >>> test/blsr_host_model.sv
// Purpose: host side of the two-wire management bus, driven by bench calls
// Assumes: sda has a pull-up; scl high lasts 5 clk and scl low 6 clk, data moves 1 clk after scl falls
// Notes:   host only pulls sda low or lets go, never drives it high
`timescale 1ns/100ps
`default_nettype none
module blsr_host_model (
  // clock
  input  wire logic clk,
  // bus
  output logic      scl,
  output logic      sda_oe_n,
  input  wire logic sda
);
  initial begin
    scl      = 1'b1;
    sda_oe_n = 1'b1;
  end
  task automatic half();
    repeat (5) @(posedge clk);
  endtask : half
  // one bit; sda moves a clk after scl fell so no false start or stop is seen
  task automatic bitc(input logic b, output logic s);
    @(posedge clk);
    sda_oe_n <= b;
    half();
    scl <= 1'b1;
    half();
    s = sda;
    scl <= 1'b0;
  endtask : bitc
  // start is line(1,0) then scl low; stop is line(0,1)
  task automatic line(input logic a, input logic b);
    @(posedge clk);
    sda_oe_n <= a;
    half();
    scl <= 1'b1;
    half();
    sda_oe_n <= b;
    half();
  endtask : line
  task automatic send(input logic [7:0] d, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) bitc(d[i], s);
    bitc(1'b1, s);
    ok = ok & ~s;
  endtask : send
  task automatic access(input logic [6:0] dev, input logic wr, input logic [7:0] ptr, input logic [7:0] wd,
                        output logic [7:0] rd, output logic ok);
    logic s;
    ok = 1'b1;
    rd = 8'h00;
    line(1'b1, 1'b0);
    scl <= 1'b0;
    send({dev, 1'b0}, ok);
    send(ptr, ok);
    if (wr) begin
      send(wd, ok);
    end else begin
      line(1'b1, 1'b0);
      scl <= 1'b0;
      send({dev, 1'b1}, ok);
      for (int i = 7; i >= 0; i--) bitc(1'b1, rd[i]);
      bitc(1'b1, s);
    end
    line(1'b0, 1'b1);
  endtask : access
endmodule : blsr_host_model
`default_nettype wire

// >>> test/test_boost_limit_status_regs.sv
// Purpose: self-checking bench for the limit and status registers
// Assumes: register traffic goes only through the host model
// Notes:   mode inputs packed in md, event inputs in ev
`timescale 1ns/100ps
`default_nettype none
module test_boost_limit_status_regs;
  import blsr_pkg::*;
  localparam logic [6:0] DEV = 7'h2a;  // arbitrary bus address
  logic        clk, rstn, scl, host_oe_n, dev_oe_n, dev_sda_o, sda, ok, seen;
  logic        reg_reset_req, reg_reset_clear, hi_en, lo_en, valley_en;
  logic [4:0]  md;
  logic [3:0]  ev;
  logic [7:0]  rd;
  logic [13:0] valley_ma;
  int          n_errors = 0;
  int          checks_done = 0;
  // open drain wire with pull-up
  assign sda = host_oe_n & (dev_oe_n | dev_sda_o);
  blsr_regs #(.DEV_ADDR(DEV)) uut (
    .clk(clk), .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_o(dev_sda_o), .sda_oe_n(dev_oe_n),
    .reg_reset_req(reg_reset_req), .reg_reset_clear(reg_reset_clear),
    .boost_mode(md[4]), .pfm_mode(md[3]), .soft_start(md[2]), .forced_bypass(md[1]), .vout_in_range(md[0]),
    .thermal_trip(ev[3]), .bypass_limit_hit(ev[2]), .boost_limit_hit(ev[1]), .fault_event(ev[0]),
    .bypass_high_limit_en(hi_en), .bypass_low_limit_en(lo_en), .valley_limit_en(valley_en),
    .valley_limit_ma(valley_ma)
  );
  blsr_host_model host (.clk(clk), .scl(scl), .sda_oe_n(host_oe_n), .sda(sda));
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    host.access(DEV, 1'b1, a, d, rd, ok);
    chk(14'(ok), 14'h1);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    host.access(DEV, 1'b0, a, 8'h00, rd, ok);
    chk(14'(ok), 14'h1);
    chk(14'(rd), 14'(exp));
  endtask : rreg
  task automatic setm(input logic [4:0] m);
    @(posedge clk);
    md <= m;
  endtask : setm
  // one-cycle event burst; flags must outlive it until read
  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 4'h0;
  endtask : pulse
  task automatic wrap_up();
    $display("counts: errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // whole run needs about 14.5k cycles
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    rstn = 1'b0;
    reg_reset_req = 1'b0;
    md = 5'b10000;
    ev = 4'h0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(valley_ma, 14'd7000);
    rreg(LIMIT_ADDR, LIMIT_RESET);
    rreg(STATUS_ADDR, STATUS_RESET);
    rreg(8'h10, 8'h00);
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      wreg(LIMIT_ADDR, 8'(c));
      chk(valley_ma, (c >= 10) ? 14'd9000 : 14'(4000 + 500 * c));
      chk(14'(valley_en), 14'h1);
    end
    wreg(LIMIT_ADDR, 8'h20);
    chk(14'(valley_en), 14'h0);
    rreg(LIMIT_ADDR, 8'h20);
    setm(5'b10100);
    wreg(LIMIT_ADDR, 8'h13);
    chk(valley_ma, 14'd2000);
    wreg(LIMIT_ADDR, 8'h03);
    chk(valley_ma, 14'd5500);
    $display("test valley done");
    setm(5'b01010);
    for (int k = 0; k < 4; k++) begin
      wreg(LIMIT_ADDR, 8'(k * 64));
      chk(14'(hi_en), 14'(k < 2));
      chk(14'(lo_en), 14'(k % 2 == 0));
    end
    rreg(STATUS_ADDR, 8'h21);
    setm(5'b10001);
    rreg(STATUS_ADDR, 8'h11);
    wreg(STATUS_ADDR, 8'hff);
    rreg(STATUS_ADDR, 8'h11);
    $display("test live status done");
    setm(5'b00001);
    pulse(4'hf);
    rreg(STATUS_ADDR, 8'h8b);
    rreg(STATUS_ADDR, 8'h01);
    setm(5'b10001);
    pulse(4'h6);
    rreg(STATUS_ADDR, 8'h15);
    rreg(STATUS_ADDR, 8'h11);
    host.access(7'h2b, 1'b0, LIMIT_ADDR, 8'h00, rd, ok);
    chk(14'(ok), 14'h0);
    $display("test flags done");
    wreg(LIMIT_ADDR, 8'hff);
    pulse(4'h8);
    @(posedge clk);
    reg_reset_req <= 1'b1;
    @(posedge clk);
    reg_reset_req <= 1'b0;
    seen = 1'b0;
    repeat (3) begin
      // sampled before the edge updates it; the clear pulse stands for one cycle only
      @(posedge clk);
      if (reg_reset_clear === 1'b1) seen = 1'b1;
    end
    chk(14'(seen), 14'h1);
    chk(valley_ma, 14'd7000);
    rreg(LIMIT_ADDR, LIMIT_RESET);
    rreg(STATUS_ADDR, 8'h11);
    $display("test register reset done");
    wrap_up();
  end
endmodule : test_boost_limit_status_regs
`default_nettype wire
